// ===== clkctl_buffer.sv
// Clock network source select and gate buffer, top level
//
// Function
// - Global source static or from logic select
// - Global mode switches among four inputs
// - Dynamic select honoured only in user mode
// - Static select may fix any input
// - Regional source fixed, never switched at run
// - Regional modes take exactly one input
// - Regional pin sources only top/bottom pins
// - External clock-out accepts only PLL source
// - Clock-out pin forwards signal or buffer
// - Enable gates every network kind
// - Enable sampled on selected clock falling edge
// - Disabled network holds still
module clkctl_buffer
  import clkctl_pkg::*;
#(
  parameter int unsigned NUM_INPUTS = CLKCTL_NUM_INPUTS
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire clkctl_cfg_t cfg_i,
  input wire logic user_mode_i,
  input wire logic [NUM_INPUTS-1:0] clk_src_i,
  input wire logic [CLKCTL_SEL_W-1:0] dyn_sel_i,
  input wire logic ena_i,
  input wire logic gen_sig_i,
  output logic net_clk_o,
  output logic ext_pin_o,
  output clkctl_status_t status_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [CLKCTL_SEL_W-1:0] sel_q;
  logic [CLKCTL_SEL_W-1:0] sel_d;
  logic cur_clk;
  logic src_legal;
  logic ena_eff;
  logic fall;
  logic ena_q;
  logic ext_pin_q;
  logic is_regional;

  assign is_regional = (cfg_i.mode == CLKCTL_MODE_REGIONAL) ||
                       (cfg_i.mode == CLKCTL_MODE_DUAL_REGIONAL);

  // ----------------------------------------------------------------
  // Source choice per mode
  // ----------------------------------------------------------------
  always_comb begin
    sel_d = sel_q;
    unique case (cfg_i.mode)
      CLKCTL_MODE_GLOBAL: begin
        if (cfg_i.dyn_sel_en) begin
          if (user_mode_i) begin
            sel_d = dyn_sel_i;
          end
        end else begin
          sel_d = cfg_i.static_sel;
        end
      end
      CLKCTL_MODE_REGIONAL, CLKCTL_MODE_DUAL_REGIONAL: begin
        sel_d = CLKCTL_SINGLE_INPUT;
      end
      CLKCTL_MODE_EXTERNAL: begin
        sel_d = cfg_i.static_sel;
      end
    endcase
  end

  // Legal source kind for the driven network
  always_comb begin
    src_legal = 1'b1;
    if (is_regional) begin
      src_legal = (cfg_i.src_kind[CLKCTL_SINGLE_INPUT] != CLKCTL_SRC_PIN_SIDE);
    end else if (cfg_i.mode == CLKCTL_MODE_EXTERNAL) begin
      src_legal = (cfg_i.src_kind[cfg_i.static_sel] == CLKCTL_SRC_PLL);
    end
  end

  // ----------------------------------------------------------------
  // Select register, moved only while the current clock is low
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      sel_q <= CLKCTL_SEL_RST;
    end else if (!cur_clk) begin
      sel_q <= sel_d;
    end
  end

  assign cur_clk = clk_src_i[sel_q];

  // ----------------------------------------------------------------
  // Enable path, high lets the clock through on every network kind whose source kind is legal
  // ----------------------------------------------------------------
  assign ena_eff = ena_i & src_legal;

  clkctl_gate u_gate (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .clk_smp_i(cur_clk),
    .ena_i(ena_eff),
    .fall_o(fall),
    .ena_q_o(ena_q),
    .gated_o(net_clk_o)
  );

  // ----------------------------------------------------------------
  // Dual-purpose clock-out pin multiplexer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ext_pin_q <= CLKCTL_OUT_RST;
    end else begin
      ext_pin_q <= cfg_i.ext_use_buf ? net_clk_o : gen_sig_i;
    end
  end

  assign ext_pin_o = ext_pin_q;

  // Status view
  assign status_o.sel = sel_q;
  assign status_o.ena = ena_q;
  assign status_o.src_legal = src_legal;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  a_ena_fall_only: assert property (
    $changed(ena_q) |-> $past(fall)
  ) else $error("enable latch changed away from a falling edge");

  a_quiet_disabled: assert property (
    (!ena_q && !fall) |=> !net_clk_o
  ) else $error("network toggled while disabled");

  a_pulse_follow: assert property (
    (ena_q && !fall && cur_clk) |=> net_clk_o
  ) else $error("enabled high clock not passed");

  a_regional_single: assert property (
    (is_regional && !cur_clk) |=> (sel_q == CLKCTL_SINGLE_INPUT)
  ) else $error("regional network not on its single input");

  a_config_hold: assert property (
    (cfg_i.mode == CLKCTL_MODE_GLOBAL && cfg_i.dyn_sel_en && !user_mode_i)
      |=> $stable(sel_q)
  ) else $error("select moved outside user mode");

  a_dyn_follow: assert property (
    (cfg_i.mode == CLKCTL_MODE_GLOBAL && cfg_i.dyn_sel_en && user_mode_i && !cur_clk)
      |=> (sel_q == $past(dyn_sel_i))
  ) else $error("dynamic select not followed");

  a_static_sel: assert property (
    (cfg_i.mode == CLKCTL_MODE_GLOBAL && !cfg_i.dyn_sel_en && !cur_clk)
      |=> (sel_q == $past(cfg_i.static_sel))
  ) else $error("static select not applied");

  a_ext_pll_only: assert property (
    (cfg_i.mode == CLKCTL_MODE_EXTERNAL &&
     cfg_i.src_kind[cfg_i.static_sel] != CLKCTL_SRC_PLL && fall) |=> !ena_q
  ) else $error("clock-out enabled from a non-PLL source");

  a_edge_pin: assert property (
    (is_regional && cfg_i.src_kind[CLKCTL_SINGLE_INPUT] == CLKCTL_SRC_PIN_SIDE && fall)
      |=> !ena_q
  ) else $error("regional network fed from a side pin");

  a_ext_mux: assert property (
    cfg_i.ext_use_buf |=> (ext_pin_o == $past(net_clk_o))
  ) else $error("clock-out pin not following buffer");

  a_ext_general: assert property (
    !cfg_i.ext_use_buf |=> (ext_pin_o == $past(gen_sig_i))
  ) else $error("clock-out pin not following general signal");

  c_sel_switch: cover property ($changed(sel_q));
  c_ena_off: cover property (ena_q ##1 !ena_q);
  c_ext_run: cover property (cfg_i.mode == CLKCTL_MODE_EXTERNAL && net_clk_o);
  c_regional_run: cover property (is_regional && net_clk_o);

endmodule : clkctl_buffer

// ===== clkctl_buffer_bench.sv
// Self-checking bench for the clock network buffer
module clkctl_buffer_bench
  import clkctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'h0;
  logic reset_i = 1'h1;
  logic user_mode_i = 1'h0;
  logic gen_sig_i = 1'h0;
  logic want_ena = 1'h0;
  logic [1:0] want_sel = 2'h0;
  logic [7:0] hi;
  clkctl_cfg_t cfg;
  logic [3:0] clk_src;
  logic [1:0] dyn_sel;
  logic ena, net_clk_o, ext_pin_o;
  clkctl_status_t status_o;
  int n_errors = 0;
  int compares = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  clkctl_user_logic user (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .want_sel_i(want_sel), .want_ena_i(want_ena), .dyn_sel_o(dyn_sel),
    .ena_o(ena), .clk_src_o(clk_src));

  clkctl_buffer dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .cfg_i(cfg),
    .user_mode_i(user_mode_i), .clk_src_i(clk_src), .dyn_sel_i(dyn_sel),
    .ena_i(ena), .gen_sig_i(gen_sig_i), .net_clk_o(net_clk_o),
    .ext_pin_o(ext_pin_o), .status_o(status_o));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Run n cycles, count cycles with the network high
  task run(input int n);
    hi = 8'h0;
    repeat (n) begin
      @(posedge ref_clk_i);
      #1;
      hi = hi + {7'h0, net_clk_o};
    end
  endtask : run

  task test_done();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    cfg.mode = CLKCTL_MODE_GLOBAL;
    cfg.dyn_sel_en = 1'h1;
    cfg.static_sel = 2'h0;
    cfg.src_kind = {4{CLKCTL_SRC_PLL}};
    cfg.ext_use_buf = 1'h1;
    repeat (4) @(posedge ref_clk_i);
    reset_i <= 1'h0;
    user_mode_i <= 1'h1;
    want_ena <= 1'h1;
    // Dynamic switching over all four inputs
    for (int s = 0; s < 4; s++) begin
      want_sel <= 2'(s);
      run(40);
      chk(8'(status_o.sel), 8'(s));
      chk(8'(hi != 8'h0), 8'h1);
    end
    $display("test dynamic select done");
    user_mode_i <= 1'h0;
    want_sel <= 2'h1;
    run(40);
    chk(8'(status_o.sel), 8'h3);
    user_mode_i <= 1'h1;
    want_ena <= 1'h0;
    run(20);
    run(40);
    chk(8'(status_o.ena), 8'h0);
    chk(hi, 8'h0);
    $display("test user mode and disable done");
    want_ena <= 1'h1;
    cfg.dyn_sel_en <= 1'h0;
    cfg.static_sel <= 2'h2;
    run(40);
    chk(8'(status_o.sel), 8'h2);
    cfg.mode <= CLKCTL_MODE_REGIONAL;
    run(40);
    chk(8'(status_o.sel), 8'h0);
    chk(8'(hi != 8'h0), 8'h1);
    cfg.src_kind[0] <= CLKCTL_SRC_PIN_SIDE;
    run(20);
    run(40);
    chk(hi, 8'h0);
    chk(8'(status_o.src_legal), 8'h0);
    cfg.mode <= CLKCTL_MODE_DUAL_REGIONAL;
    run(40);
    chk(8'(status_o.sel), 8'h0);
    chk(hi, 8'h0);
    $display("test static and regional done");
    // External path runs from the static select, input 2
    cfg.mode <= CLKCTL_MODE_EXTERNAL;
    cfg.src_kind[2] <= CLKCTL_SRC_LOGIC;
    run(20);
    run(40);
    chk(hi, 8'h0);
    chk(8'(status_o.src_legal), 8'h0);
    cfg.src_kind[2] <= CLKCTL_SRC_PLL;
    run(20);
    run(40);
    chk(8'(hi != 8'h0), 8'h1);
    chk(8'(status_o.src_legal), 8'h1);
    cfg.ext_use_buf <= 1'h0;
    gen_sig_i <= 1'h1;
    run(3);
    chk(8'(ext_pin_o), 8'h1);
    gen_sig_i <= 1'h0;
    run(3);
    chk(8'(ext_pin_o), 8'h0);
    $display("test external path done");
    test_done();
  end
endmodule : clkctl_buffer_bench

// ===== clkctl_pkg.sv
// Package and edge-sampled enable gate for the clock network control buffer
package clkctl_pkg;

  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CLKCTL_NUM_INPUTS = 4;
  localparam int unsigned CLKCTL_SEL_W = 2;
  localparam logic [1:0] CLKCTL_SEL_RST = 2'h0;
  localparam logic [1:0] CLKCTL_SINGLE_INPUT = 2'h0;
  localparam logic CLKCTL_ENA_RST = 1'h0;
  localparam logic CLKCTL_PREV_RST = 1'h0;
  localparam logic CLKCTL_OUT_RST = 1'h0;

  // ----------------------------------------------------------------
  // Network being driven
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CLKCTL_MODE_GLOBAL,
    CLKCTL_MODE_REGIONAL,
    CLKCTL_MODE_DUAL_REGIONAL,
    CLKCTL_MODE_EXTERNAL
  } clkctl_mode_t;

  // ----------------------------------------------------------------
  // Kind of source wired to each candidate input
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CLKCTL_SRC_PIN_EDGE,
    CLKCTL_SRC_PIN_SIDE,
    CLKCTL_SRC_LOGIC,
    CLKCTL_SRC_PLL
  } clkctl_src_t;

  // Static configuration, fixed before user operation
  typedef struct packed {
    clkctl_mode_t mode;
    logic dyn_sel_en;
    logic [1:0] static_sel;
    clkctl_src_t [3:0] src_kind;
    logic ext_use_buf;
  } clkctl_cfg_t;

  // Observable state of the buffer
  typedef struct packed {
    logic [1:0] sel;
    logic ena;
    logic src_legal;
  } clkctl_status_t;

endpackage : clkctl_pkg

// ------------------------------------------------------------------
// Enable latched at falling edge of the selected clock, AND gate out
// ------------------------------------------------------------------
module clkctl_gate
  import clkctl_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic clk_smp_i,
  input wire logic ena_i,
  output logic fall_o,
  output logic ena_q_o,
  output logic gated_o
);

  logic prev_q;
  logic ena_q;
  logic ena_d;
  logic gated_q;

  // Falling edge of the sampled clock
  assign fall_o = prev_q & ~clk_smp_i;
  assign ena_d = fall_o ? ena_i : ena_q;

  // Previous clock level
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      prev_q <= CLKCTL_PREV_RST;
    end else begin
      prev_q <= clk_smp_i;
    end
  end

  // Enable taken only at a falling edge
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ena_q <= CLKCTL_ENA_RST;
    end else begin
      ena_q <= ena_d;
    end
  end

  // Whole high pulses only, low while disabled
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      gated_q <= CLKCTL_OUT_RST;
    end else begin
      gated_q <= clk_smp_i & ena_d;
    end
  end

  assign ena_q_o = ena_q;
  assign gated_o = gated_q;

endmodule : clkctl_gate

// ===== clkctl_user_logic.sv
// User logic model: candidate clocks, select and enable drivers
module clkctl_user_logic
  import clkctl_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [1:0] want_sel_i,
  input wire logic want_ena_i,
  output logic [1:0] dyn_sel_o,
  output logic ena_o,
  output logic [3:0] clk_src_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0][3:0] cnt_q;

  // ------------------------------------------------------------
  // Slow candidate clocks, half period k+2 cycles
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    for (int k = 0; k < 4; k++) begin
      if (reset_i || cnt_q[k] == 4'(k + 1)) begin
        cnt_q[k] <= 4'h0;
        clk_src_o[k] <= reset_i ? 1'h0 : ~clk_src_o[k];
      end else begin
        cnt_q[k] <= cnt_q[k] + 4'h1;
      end
    end
  end

  // Select and active-high enable, registered
  always_ff @(posedge ref_clk_i) begin
    dyn_sel_o <= want_sel_i;
    ena_o <= want_ena_i;
  end
endmodule : clkctl_user_logic
